/* hw/hlsm_ctrl.v */
// hlsm_ctrl.v: duty-cycle sampling controller for a micro-power magnetic latch
// assumes: mode pins and the comparator level come from outside sys_clk;
// a floating mode pin is pulled low at the pad before reaching this module
`timescale 1ns/1ps
`default_nettype none
`include "hlsm_consts.vh"
module hlsm_ctrl
#(
  parameter CW              = 32,
  parameter AWAKE_CYC       = `HLSM_AWAKE_CYC,
  parameter SLEEP_NORM_CYC  = `HLSM_SLEEP_NORM_CYC,
  parameter SLEEP_SLOW_CYC  = `HLSM_SLEEP_SLOW_CYC,
  parameter SLEEP_FAST_CYC  = `HLSM_SLEEP_FAST_CYC,
  parameter TIMEOUT_CYC     = `HLSM_TIMEOUT_CYC
)
(
  // clock and reset
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       clk_en,
  // mode pins, floating pins arrive as low
  input  wire       ext_ctl_pin,
  input  wire       rate_ctl_pin,
  // comparator level from the front end
  input  wire       field_level,
  // status
  output wire       awake,
  output wire       fast_rate,
  output wire [1:0] mode,
  output wire       sample_out
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire ext_s;
  wire rate_s;
  wire fld_s;
  hlsm_sync u_sync_ext  (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
                         .async_in(ext_ctl_pin), .sync_out(ext_s));
  hlsm_sync u_sync_rate (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
                         .async_in(rate_ctl_pin), .sync_out(rate_s));
  hlsm_sync u_sync_fld  (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
                         .async_in(field_level), .sync_out(fld_s));

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // a floating pin has already been pulled to 0 and decodes as low
  reg [1:0] mode_nxt;
  always @*
  begin
    case ({ext_s, rate_s})
      2'b00:   mode_nxt = `HLSM_MODE_NORM;
      2'b01:   mode_nxt = `HLSM_MODE_DUAL;
      2'b10:   mode_nxt = `HLSM_MODE_EXT_SLEEP;
      default: mode_nxt = `HLSM_MODE_EXT_AWAKE;
    endcase
  end

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  localparam [2:0] ST_AWAKE = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_HOLD  = 3'h4;

  // ----------------------------------------
  // terminal counts, sized to the counters
  // ----------------------------------------
  // counters stop at count-1, so each phase lasts exactly its count
  localparam [CW-1:0] AWAKE_LAST      = AWAKE_CYC - 1;
  localparam [CW-1:0] SLEEP_NORM_LAST = SLEEP_NORM_CYC - 1;
  localparam [CW-1:0] SLEEP_SLOW_LAST = SLEEP_SLOW_CYC - 1;
  localparam [CW-1:0] SLEEP_FAST_LAST = SLEEP_FAST_CYC - 1;
  localparam [CW-1:0] TIMEOUT_LAST    = TIMEOUT_CYC - 1;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // clk_en low freezes every counter, so a frozen phase resumes where it stopped
  reg [2:0]    state_r;
  reg [1:0]    mode_r;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] tmo_r;
  reg          fast_r;
  reg          out_r;

  wire         mode_chg = (mode_nxt != mode_r);
  wire         chg      = (fld_s != out_r);
  wire         tmo_done = (tmo_r >= TIMEOUT_LAST);

  // ----------------------------------------
  // sleep length select
  // ----------------------------------------
  // one awake length, only the sleep length depends on mode
  reg [CW-1:0] sleep_last;
  always @*
  begin
    if (mode_r == `HLSM_MODE_NORM)
      sleep_last = SLEEP_NORM_LAST;
    else if (fast_r)
      sleep_last = SLEEP_FAST_LAST;
    else
      sleep_last = SLEEP_SLOW_LAST;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_AWAKE;
      mode_r  <= `HLSM_MODE_NORM;
      cnt_r   <= {CW{1'b0}};
      tmo_r   <= {CW{1'b0}};
      fast_r  <= 1'b0;
      out_r   <= 1'b1;
    end
    else if (clk_en)
    begin
      mode_r <= mode_nxt;
      if (mode_chg)
      begin
        // restart timing on any mode change; dual always re-enters slow
        cnt_r  <= {CW{1'b0}};
        tmo_r  <= {CW{1'b0}};
        fast_r <= 1'b0;
        case (mode_nxt)
          `HLSM_MODE_EXT_SLEEP: state_r <= ST_HOLD;
          `HLSM_MODE_EXT_AWAKE: state_r <= ST_AWAKE;
          default:              state_r <= ST_AWAKE;
        endcase
        // leaving an awake phase latches the last sample
        if (state_r == ST_AWAKE && mode_nxt == `HLSM_MODE_EXT_SLEEP)
          out_r <= fld_s;
      end
      else
      begin
        // fast-rate timeout runs across awake and sleep
        if (mode_r == `HLSM_MODE_DUAL && fast_r)
        begin
          if (tmo_done)
          begin
            fast_r <= 1'b0;
            tmo_r  <= {CW{1'b0}};
          end
          else
            tmo_r <= tmo_r + 1'b1;
        end
        case (state_r)
          ST_AWAKE:
          begin
            if (mode_r == `HLSM_MODE_EXT_AWAKE)
            begin
              // continuously awake: output follows each sample
              cnt_r <= {CW{1'b0}};
              out_r <= fld_s;
            end
            else if (cnt_r >= AWAKE_LAST)
            begin
              cnt_r   <= {CW{1'b0}};
              state_r <= ST_SLEEP;
              out_r   <= fld_s;
              if (mode_r == `HLSM_MODE_DUAL && chg)
              begin
                fast_r <= 1'b1;
                tmo_r  <= {CW{1'b0}};
              end
            end
            else
              cnt_r <= cnt_r + 1'b1;
          end
          ST_SLEEP:
          begin
            // output held, no sampling while asleep
            if (cnt_r >= sleep_last)
            begin
              cnt_r   <= {CW{1'b0}};
              state_r <= ST_AWAKE;
            end
            else
              cnt_r <= cnt_r + 1'b1;
          end
          ST_HOLD:
            cnt_r <= {CW{1'b0}};
          default:
            state_r <= ST_AWAKE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // with the ext pin high, a host toggling the rate pin sets the awake length itself
  assign awake      = (state_r == ST_AWAKE);
  assign fast_rate  = fast_r;
  assign mode       = mode_r;
  assign sample_out = out_r;
endmodule // hlsm_ctrl
`default_nettype wire

/* hw/hlsm_consts.vh */
// hlsm_consts.vh: timing constants for the hall latch sample-mode controller
// assumes: sys_clk at 20 MHz; times in microseconds, counts derived from them
`ifndef HLSM_CONSTS_VH
`define HLSM_CONSTS_VH
// ----------------------------------------
// clock
// ----------------------------------------
`define HLSM_CLK_MHZ          20
// ----------------------------------------
// times (us), plain defaults
// ----------------------------------------
`define HLSM_T_AWAKE_US       40
`define HLSM_T_PERIOD_NORM_US 60000
`define HLSM_T_SLEEP_SLOW_US  120000
`define HLSM_T_TIMEOUT_US     2000000
`define HLSM_FAST_RATIO       8
// ----------------------------------------
// derived cycle counts
// ----------------------------------------
`define HLSM_AWAKE_CYC       (`HLSM_T_AWAKE_US * `HLSM_CLK_MHZ)
`define HLSM_SLEEP_NORM_CYC  ((`HLSM_T_PERIOD_NORM_US - `HLSM_T_AWAKE_US) * `HLSM_CLK_MHZ)
`define HLSM_SLEEP_SLOW_CYC  (`HLSM_T_SLEEP_SLOW_US * `HLSM_CLK_MHZ)
`define HLSM_SLEEP_FAST_CYC  (`HLSM_FAST_RATIO * `HLSM_AWAKE_CYC)
`define HLSM_TIMEOUT_CYC     (`HLSM_T_TIMEOUT_US * `HLSM_CLK_MHZ)
// ----------------------------------------
// mode codes
// ----------------------------------------
`define HLSM_MODE_NORM       2'h0
`define HLSM_MODE_DUAL       2'h1
`define HLSM_MODE_EXT_SLEEP  2'h2
`define HLSM_MODE_EXT_AWAKE  2'h3
`endif

/* hw/hlsm_sync.v */
// hlsm_sync.v: two-flop synchroniser for one pin input
// assumes: input is asynchronous to sys_clk; resets low
`timescale 1ns/1ps
`default_nettype none
module hlsm_sync
(
  // clock and reset
  input  wire sys_clk,
  input  wire reset_n,
  input  wire clk_en,
  // data
  input  wire async_in,
  output wire sync_out
);
  reg meta_r;
  reg sync_r;
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule // hlsm_sync
`default_nettype wire

/* dv/hlsm_host.sv */
// hlsm_host.sv: host model on the two mode pins
// assumes: pins move on falling edges only
`timescale 1ns/1ps
`default_nettype none
module hlsm_host
(
  input  wire logic       sys_clk,
  input  wire logic [1:0] req,
  output var  logic       ext_ctl_pin, rate_ctl_pin
);
  // an open pin reads low, so it starts low here
  initial {ext_ctl_pin, rate_ctl_pin} = 2'h0;
  // pairs are held far longer than one awake phase
  always @(negedge sys_clk) {ext_ctl_pin, rate_ctl_pin} <= req;
endmodule // hlsm_host
`default_nettype wire

/* dv/hlsm_ctrl_sva.sv */
// hlsm_ctrl_sva.sv: port checks for the sample-mode controller
// assumes: AWAKE_CYC of 4; mode pins move only while asleep or while held awake in mode 3
`timescale 1ns/1ps
`default_nettype none
module hlsm_sva #(parameter int NS = 20, parameter int FS = 32)
(
  input wire logic       sys_clk, reset_n, clk_en, ext_ctl_pin, rate_ctl_pin,
  input wire logic       awake, fast_rate, sample_out,
  input wire logic [1:0] mode
);
  // one cycle of slack either side of a sleep
  localparam int NL = NS - 1, NH = NS + 1, FL = FS - 1, FH = FS + 1;
  default clocking @(posedge sys_clk); endclocking
  // a frozen clock enable stretches every phase, so attempts in flight are dropped
  default disable iff (!reset_n || !clk_en);
  a_mode_decode: assert property (
    ($stable({ext_ctl_pin, rate_ctl_pin}) && clk_en)[*5] |-> mode == {ext_ctl_pin, rate_ctl_pin})
    else $error("mode decode");
  a_ext_sleep: assert property (
    mode == 2'h2 && $stable(mode) |-> !awake && $stable(sample_out)) else $error("ext sleep");
  a_ext_awake: assert property (
    mode == 2'h3 && $stable(mode) |-> awake) else $error("ext awake");
  a_fast_switch: assert property (
    $fell(awake) && mode == 2'h1 && $changed(sample_out) |-> fast_rate) else $error("no fast");
  a_fast_sleep: assert property (
    $fell(awake) && fast_rate && $stable(fast_rate) |->
    ##[FL:FH] ($rose(awake) || !fast_rate || mode != 2'h1)) else $error("fast sleep");
  a_norm_sleep: assert property (
    $fell(awake) && mode == 2'h0 |-> ##[NL:NH] ($rose(awake) || mode != 2'h0))
    else $error("normal sleep");
  a_awake_len: assert property (
    $rose(awake) && !mode[1] |-> awake[*4] ##1 !awake) else $error("awake length");
  a_out_hold: assert property (
    $changed(sample_out) |-> $fell(awake) || mode == 2'h3 || $changed(mode)) else $error("hold");
endmodule // hlsm_sva
bind hlsm_ctrl hlsm_sva #(.NS(SLEEP_NORM_CYC), .FS(SLEEP_FAST_CYC)) hlsm_sva_i (.sys_clk,
  .reset_n, .clk_en, .ext_ctl_pin, .rate_ctl_pin, .awake, .fast_rate, .sample_out, .mode);
`default_nettype wire

/* dv/hlsm_ctrl_test.sv */
// hlsm_ctrl_test.sv: scenario bench for the sample-mode controller
// assumes: hlsm_host drives the mode pins; clk_en high except in the freeze scenario
`timescale 1ns/1ps
`default_nettype none
module hlsm_ctrl_test;
  logic       sys_clk = 1'b0, reset_n = 1'b0, field_level = 1'b0, clk_en = 1'b1;
  logic       ext_ctl_pin, rate_ctl_pin, awake, fast_rate, sample_out;
  logic [1:0] req = 2'h0, mode;
  int         n_fail = 0, compares = 0;
  always #25 sys_clk = ~sys_clk;
  hlsm_host hlsm_host_i (.sys_clk, .req, .ext_ctl_pin, .rate_ctl_pin);
  hlsm_ctrl #(.AWAKE_CYC(4), .SLEEP_NORM_CYC(20), .SLEEP_SLOW_CYC(40), .SLEEP_FAST_CYC(32),
    .TIMEOUT_CYC(200)) hlsm_ctrl_i (.sys_clk, .reset_n, .clk_en, .ext_ctl_pin,
    .rate_ctl_pin, .field_level, .awake, .fast_rate, .mode, .sample_out);
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic till(input logic v);
    int i;
    for (i = 0; i < 200 && awake !== v; i++)
      @(negedge sys_clk);
    if (i == 200)
    begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic t_norm;
    till(1'b0);
    chk(sample_out, 1'b0);
    field_level = 1'b1;
    till(1'b1);
    chk(sample_out, 1'b0);
    till(1'b0);
    chk({mode, sample_out}, 3'h1);
    cyc(8);
  endtask
  task automatic t_dual;
    req <= 2'h1;
    cyc(5);
    chk({mode, fast_rate}, 3'h2);
    till(1'b0);
    chk(fast_rate, 1'b0);
    field_level = 1'b0;
    till(1'b1);
    till(1'b0);
    chk({fast_rate, sample_out}, 2'h2);
    cyc(190);
    chk(fast_rate, 1'b1);
    cyc(20);
    chk(fast_rate, 1'b0);
  endtask
  task automatic t_ext;
    till(1'b0);
    req <= 2'h3;
    cyc(8);
    field_level = 1'b1;
    cyc(6);
    chk({awake, sample_out}, 2'h3);
    req <= 2'h2;
    cyc(6);
    field_level = 1'b0;
    cyc(50);
    chk({mode, awake, sample_out}, 4'h9);
  endtask
  task automatic t_freeze;
    req <= 2'h0;
    cyc(5);
    till(1'b0);
    clk_en = 1'b0;
    field_level = 1'b1;
    cyc(40);
    chk({awake, mode, sample_out}, 4'h0);
    clk_en = 1'b1;
    cyc(15);
    chk(awake, 1'b0);
    till(1'b1);
    till(1'b0);
    chk(sample_out, 1'b1);
  endtask
  initial
  begin
    cyc(20);
    chk({awake, fast_rate, mode, sample_out}, 5'h11);
    reset_n = 1'b1;
    t_norm();
    t_dual();
    t_ext();
    t_freeze();
    conclude();
  end
endmodule // hlsm_ctrl_test
`default_nettype wire
